// ==== sams_top.sv ====
// Audio-mode serial port: APB register file, bit clock, interrupt.
// Assumes pclk at 100 MHz, zero-wait APB master, pins from outside.
//
// What this block does
// [R1] Software clears both buffer words first
// [R2] Software clears flags before enabling interrupts
// [R3] Three-bit interrupt priority field, software written
// [R4] Audio select bit selects audio operation
// [R5] Receive overflow flag at status bit six
// [R6] Port runs only with enable, config frozen
// [R7] Transfer starts once both buffer words written
// [R8] Three control and two status registers
// [R9] Baud divider sets generated bit clock rate
// [R10] Low mask register (MSKL) gates events onto interrupt
// [R11] Underrun words sent when no fresh data
// [R12] Bit clock runs freely, every frame transfers
// [R13] Master drives bit clock and channel clock
// [R14] Four formats: I2S, left, right, PCM
`timescale 1ns/1ps
`default_nettype none
module sams_top
   import sams_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [SAMS_AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic [SAMS_PRIO_W-1:0] irq_priority,
   input wire logic bit_clock_pin_i,
   output logic bit_clock_pin_o,
   output logic bit_clock_pin_oe_n,
   input wire logic channel_clock_i,
   output logic channel_clock_o,
   output logic channel_clock_oe_n,
   input wire logic serial_data_i,
   output logic serial_data_o
);

   sams_eng_if eng_if ();

   logic [SAMS_DW-1:0] con1l_r;
   logic [SAMS_DW-1:0] con1h_r;
   logic [SAMS_DW-1:0] con2l_r;
   logic [SAMS_DW-1:0] baud_r;
   logic [SAMS_DW-1:0] mskl_r;
   logic [SAMS_DW-1:0] mskh_r;
   logic [SAMS_DW-1:0] url_r;
   logic [SAMS_DW-1:0] urh_r;
   logic [SAMS_DW-1:0] bufl_r;
   logic [SAMS_DW-1:0] bufh_r;
   logic [SAMS_DW-1:0] rxl_r;
   logic [SAMS_DW-1:0] rxr_r;
   logic [SAMS_DW-1:0] div_r;
   logic [SAMS_DW-1:0] rdata;
   logic [SAMS_PRIO_W-1:0] prio_r;
   logic [SAMS_IRQ_W-1:0] flag_r;
   logic [SAMS_IRQ_W-1:0] ev;
   logic [2:0] s1_r;
   logic [2:0] s2_r;
   logic [2:0] s3_r;
   logic [2:0] st_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic rov_r;
   logic txfull_r;
   logic lowwr_r;
   logic highwr_r;
   logic started_r;
   logic rxfull_r;
   logic sck_r;
   logic sck_prev_r;
   logic drive_r;
   logic setup;
   logic acc_wr;
   logic acc_rd;
   logic hit;
   logic en;
   logic audio;
   logic run;
   logic master;
   logic tick;
   logic wr_bufl;
   logic wr_bufh;
   logic pair_done;
   logic rd_flag;
   logic rd_bufl;
   logic ovf;

   function automatic logic [SAMS_DW-1:0] wmerge(input logic [SAMS_DW-1:0] old);
      return {pstrb[1] ? pwdata[15:8] : old[15:8],
              pstrb[0] ? pwdata[7:0] : old[7:0]};
   endfunction

   assign setup = psel && !penable;
   assign acc_wr = psel && penable && pwrite;
   assign acc_rd = psel && penable && !pwrite;
   assign en = con1l_r[SAMS_B_PORT_EN];
   assign audio = con1h_r[SAMS_B_AUDIO];
   assign master = con1l_r[SAMS_B_MASTER];
   assign run = en && audio && started_r; // [R6]
   assign wr_bufl = acc_wr && paddr == SAMS_A_BUFL;
   assign wr_bufh = acc_wr && paddr == SAMS_A_BUFH;
   assign rd_flag = acc_rd && paddr == SAMS_A_FLAG;
   assign rd_bufl = acc_rd && paddr == SAMS_A_BUFL;
   assign pair_done = en && (lowwr_r || wr_bufl) && (highwr_r || wr_bufh);

   // Configuration registers; format and rate frozen while enabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         con1l_r <= SAMS_ZERO16;
         con1h_r <= SAMS_ZERO16;
         con2l_r <= SAMS_ZERO16;
         baud_r <= SAMS_ZERO16;
         mskl_r <= SAMS_ZERO16;
         mskh_r <= SAMS_ZERO16;
         url_r <= SAMS_ZERO16;
         urh_r <= SAMS_ZERO16;
         prio_r <= '0;
      end else if (acc_wr) begin
         case (paddr)
            SAMS_A_CON1L: con1l_r <= wmerge(con1l_r); // [R6]
            SAMS_A_CON1H: if (!en) con1h_r <= wmerge(con1h_r); // [R4]
            SAMS_A_CON2L: if (!en) con2l_r <= wmerge(con2l_r); // [R8]
            SAMS_A_BAUD: if (!en) baud_r <= wmerge(baud_r); // [R9]
            SAMS_A_MSKL: mskl_r <= wmerge(mskl_r); // [R10]
            SAMS_A_MSKH: mskh_r <= wmerge(mskh_r);
            SAMS_A_URL: url_r <= wmerge(url_r); // [R11]
            SAMS_A_URH: urh_r <= wmerge(urh_r);
            SAMS_A_PRIO: if (pstrb[0]) prio_r <= pwdata[SAMS_PRIO_W-1:0]; // [R3]
            default: ;
         endcase
      end
   end

   // Transmit words; writes while disabled only store the value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bufl_r <= SAMS_ZERO16;
         bufh_r <= SAMS_ZERO16;
         lowwr_r <= 1'b0;
         highwr_r <= 1'b0;
         txfull_r <= 1'b0;
         started_r <= 1'b0;
      end else begin
         if (wr_bufl) bufl_r <= wmerge(bufl_r); // [R1]
         if (wr_bufh) bufh_r <= wmerge(bufh_r);
         if (!en) begin
            lowwr_r <= 1'b0;
            highwr_r <= 1'b0;
            txfull_r <= 1'b0;
            started_r <= 1'b0;
         end else if (pair_done) begin
            lowwr_r <= 1'b0;
            highwr_r <= 1'b0;
            txfull_r <= 1'b1;
            started_r <= started_r || audio; // [R7]
         end else begin
            lowwr_r <= lowwr_r || wr_bufl;
            highwr_r <= highwr_r || wr_bufh;
            if (eng_if.frame_start) txfull_r <= 1'b0;
         end
      end
   end

   // Receive holding words and overflow
   assign ovf = eng_if.rx_done && rxfull_r && !rd_bufl;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxl_r <= SAMS_ZERO16;
         rxr_r <= SAMS_ZERO16;
         rxfull_r <= 1'b0;
         rov_r <= 1'b0;
      end else begin
         if (eng_if.rx_done && !ovf) begin
            rxl_r <= eng_if.rx_l;
            rxr_r <= eng_if.rx_r;
         end
         rxfull_r <= eng_if.rx_done || (rxfull_r && !rd_bufl);
         if (ovf) begin
            rov_r <= 1'b1; // [R5]
         end else if (acc_wr && paddr == SAMS_A_STATL && pstrb[0]
                      && !pwdata[SAMS_B_ROV]) begin
            rov_r <= 1'b0; // [R5]
         end
      end
   end

   // Sticky event flags, cleared by reading, new events win
   always_comb begin
      ev = '0;
      ev[SAMS_I_RXDONE] = eng_if.rx_done;
      ev[SAMS_I_TXLOAD] = eng_if.frame_start && txfull_r;
      ev[SAMS_I_ROV] = ovf;
      ev[SAMS_I_TUR] = eng_if.frame_start && !txfull_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_r <= '0;
      end else begin
         flag_r <= (flag_r & ~{SAMS_IRQ_W{rd_flag}}) | ev; // [R2]
      end
   end

   assign irq = |(flag_r & mskl_r[SAMS_IRQ_W-1:0]); // [R10]
   assign irq_priority = prio_r;

   // Pin synchronisers; a level counts once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         st_r <= '0;
         sck_prev_r <= 1'b0;
      end else begin
         s1_r <= {serial_data_i, channel_clock_i, bit_clock_pin_i};
         s2_r <= s1_r;
         s3_r <= s2_r;
         st_r <= ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & st_r);
         sck_prev_r <= st_r[0];
      end
   end

   // Generated bit clock: half period of baud divider plus one cycles
   assign tick = run && master && div_r == baud_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= SAMS_ZERO16;
         sck_r <= 1'b0;
         drive_r <= 1'b0;
      end else begin
         drive_r <= run && master; // [R13]
         if (!(run && master)) begin
            div_r <= SAMS_ZERO16;
            sck_r <= 1'b0;
         end else if (tick) begin
            div_r <= SAMS_ZERO16;
            sck_r <= ~sck_r; // [R12]
         end else begin
            div_r <= div_r + 1'b1; // [R9]
         end
      end
   end

   assign eng_if.run = run;
   assign eng_if.master = master;
   assign eng_if.fmt = sams_fmt_t'(con1h_r[1:0]); // [R14]
   assign eng_if.rise_en = master ? (tick && !sck_r)
                                  : (run && st_r[0] && !sck_prev_r);
   assign eng_if.fall_en = master ? (tick && sck_r)
                                  : (run && !st_r[0] && sck_prev_r);
   assign eng_if.lr_in = st_r[1];
   assign eng_if.sdi_in = st_r[2];
   assign eng_if.tx_l = txfull_r ? bufh_r : urh_r; // [R11]
   assign eng_if.tx_r = txfull_r ? bufl_r : url_r;

   sams_engine u_engine (
      .pclk(pclk),
      .presetn(presetn),
      .e(eng_if.eng)
   );

   assign bit_clock_pin_o = sck_r;
   assign bit_clock_pin_oe_n = !drive_r;
   assign channel_clock_o = eng_if.lr_out;
   assign channel_clock_oe_n = !drive_r;
   assign serial_data_o = eng_if.sdo;

   // Read data prepared in the setup cycle, answered without wait
   always_comb begin
      rdata = SAMS_ZERO16;
      hit = 1'b1;
      case (paddr)
         SAMS_A_CON1L: rdata = con1l_r; // [R8]
         SAMS_A_CON1H: rdata = con1h_r;
         SAMS_A_CON2L: rdata = con2l_r;
         SAMS_A_STATL: begin
            rdata[SAMS_B_ROV] = rov_r;
            rdata[SAMS_B_TXFULL] = txfull_r;
            rdata[SAMS_B_RXFULL] = rxfull_r;
         end
         SAMS_A_STATH: begin
            rdata[SAMS_B_RUN] = run;
            rdata[SAMS_B_DRIVE] = drive_r;
         end
         SAMS_A_BUFL: rdata = rxr_r;
         SAMS_A_BUFH: rdata = rxl_r;
         SAMS_A_BAUD: rdata = baud_r;
         SAMS_A_MSKL: rdata = mskl_r;
         SAMS_A_MSKH: rdata = mskh_r;
         SAMS_A_URL: rdata = url_r;
         SAMS_A_URH: rdata = urh_r;
         SAMS_A_PRIO: rdata[SAMS_PRIO_W-1:0] = prio_r;
         SAMS_A_FLAG: rdata[SAMS_IRQ_W-1:0] = flag_r;
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= '0;
         pslverr_r <= 1'b0;
      end else if (setup) begin
         prdata_r <= {SAMS_ZERO16, rdata};
         pslverr_r <= !hit;
      end
   end

   assign prdata = prdata_r;
   assign pslverr = pslverr_r;
   assign pready = 1'b1;

   property p_run_needs_enable;
      @(posedge pclk) disable iff (!presetn)
      eng_if.fall_en |-> (en && audio && started_r);
   endproperty
   a_run_needs_enable: assert property (p_run_needs_enable) // [R6]
      else $error("Bit clock step while port not enabled");

   property p_audio_start;
      @(posedge pclk) disable iff (!presetn)
      $rose(started_r) |-> $past(pair_done) && $past(audio);
   endproperty
   a_audio_start: assert property (p_audio_start) // [R7]
      else $error("Transfer started without both buffer words");

   property p_audio_select;
      @(posedge pclk) disable iff (!presetn)
      !audio |=> !eng_if.run;
   endproperty
   a_audio_select: assert property (p_audio_select) // [R4]
      else $error("Port running without audio select");

   property p_ovf_flag;
      @(posedge pclk) disable iff (!presetn)
      ovf |=> rov_r && flag_r[SAMS_I_ROV] && rxl_r == $past(rxl_r);
   endproperty
   a_ovf_flag: assert property (p_ovf_flag) // [R5]
      else $error("Overflow not flagged or holding word overwritten");

   property p_prio_write;
      @(posedge pclk) disable iff (!presetn)
      (acc_wr && paddr == SAMS_A_PRIO && pstrb[0])
         |=> irq_priority == $past(pwdata[SAMS_PRIO_W-1:0]);
   endproperty
   a_prio_write: assert property (p_prio_write) // [R3]
      else $error("Priority field did not take written value");

   property p_underrun_word;
      @(posedge pclk) disable iff (!presetn)
      ev[SAMS_I_TUR] |-> $past(!txfull_r) && eng_if.tx_l == urh_r;
   endproperty
   a_underrun_word: assert property (p_underrun_word) // [R11]
      else $error("Underrun without underrun word selected");

   property p_irq_clear;
      @(posedge pclk) disable iff (!presetn)
      (rd_flag && ev == '0) |=> !irq;
   endproperty
   a_irq_clear: assert property (p_irq_clear) // [R10]
      else $error("Interrupt still high after flag read");

   property p_sck_hold;
      @(posedge pclk) disable iff (!presetn)
      (run && master && div_r != baud_r && $stable(baud_r)) |=> $stable(sck_r);
   endproperty
   a_sck_hold: assert property (p_sck_hold) // [R9]
      else $error("Bit clock toggled before divider count");

   property p_read_ctrl;
      @(posedge pclk) disable iff (!presetn)
      (setup && paddr == SAMS_A_CON1H)
         |=> prdata[SAMS_DW-1:0] == $past(con1h_r);
   endproperty
   a_read_ctrl: assert property (p_read_ctrl) // [R8]
      else $error("Control register read back wrong");

   property p_master_drive;
      @(posedge pclk) disable iff (!presetn)
      (run && master) |=> !bit_clock_pin_oe_n && !channel_clock_oe_n;
   endproperty
   a_master_drive: assert property (p_master_drive) // [R13]
      else $error("Master not driving bit and channel clocks");

endmodule // sams_top
`default_nettype wire

// ==== sams_pkg.sv ====
// Constants, register map and types of the audio-mode serial port.
// Assumes a 16-bit register file reached over APB with 32-bit data.
package sams_pkg;

   localparam int SAMS_DW = 16;
   localparam int SAMS_AW = 8;
   localparam int SAMS_POS_W = 6;
   localparam int SAMS_PRIO_W = 3;
   localparam int SAMS_IRQ_W = 4;

   // Byte addresses, one aligned word each
   localparam logic [SAMS_AW-1:0] SAMS_A_CON1L = 8'h00;
   localparam logic [SAMS_AW-1:0] SAMS_A_CON1H = 8'h04;
   localparam logic [SAMS_AW-1:0] SAMS_A_CON2L = 8'h08;
   localparam logic [SAMS_AW-1:0] SAMS_A_STATL = 8'h0c;
   localparam logic [SAMS_AW-1:0] SAMS_A_STATH = 8'h10;
   localparam logic [SAMS_AW-1:0] SAMS_A_BUFL = 8'h14;
   localparam logic [SAMS_AW-1:0] SAMS_A_BUFH = 8'h18;
   localparam logic [SAMS_AW-1:0] SAMS_A_BAUD = 8'h1c;
   localparam logic [SAMS_AW-1:0] SAMS_A_MSKL = 8'h20;
   localparam logic [SAMS_AW-1:0] SAMS_A_MSKH = 8'h24;
   localparam logic [SAMS_AW-1:0] SAMS_A_URL = 8'h28;
   localparam logic [SAMS_AW-1:0] SAMS_A_URH = 8'h2c;
   localparam logic [SAMS_AW-1:0] SAMS_A_PRIO = 8'h30;
   localparam logic [SAMS_AW-1:0] SAMS_A_FLAG = 8'h34;

   // Field positions
   localparam int SAMS_B_PORT_EN = 15;
   localparam int SAMS_B_MASTER = 5;
   localparam int SAMS_B_AUDIO = 15;
   localparam int SAMS_B_ROV = 6;
   localparam int SAMS_B_TXFULL = 1;
   localparam int SAMS_B_RXFULL = 0;
   localparam int SAMS_B_RUN = 0;
   localparam int SAMS_B_DRIVE = 1;
   localparam int SAMS_I_RXDONE = 0;
   localparam int SAMS_I_TXLOAD = 1;
   localparam int SAMS_I_ROV = 2;
   localparam int SAMS_I_TUR = 3;
   localparam int SAMS_CH_BIT = 5;
   localparam int SAMS_PCM_CH_BIT = 4;

   localparam logic [SAMS_DW-1:0] SAMS_ZERO16 = 16'h0000;
   localparam logic [SAMS_POS_W-1:0] SAMS_POS_FIRST = 6'h00;
   localparam logic [SAMS_POS_W-1:0] SAMS_POS_RESYNC = 6'h01;
   localparam logic [SAMS_POS_W-1:0] SAMS_POS_LAST = 6'h3f;
   localparam logic [4:0] SAMS_OFF_LJ = 5'h00;
   localparam logic [4:0] SAMS_OFF_I2S = 5'h01;
   localparam logic [4:0] SAMS_OFF_RJ = 5'h10;
   localparam logic [4:0] SAMS_DATA_BITS = 5'h10;

   typedef enum logic [1:0] {
      SAMS_FMT_I2S = 2'h0,
      SAMS_FMT_LJ = 2'h1,
      SAMS_FMT_RJ = 2'h3,
      SAMS_FMT_PCM = 2'h2
   } sams_fmt_t;

endpackage

// ==== sams_eng_if.sv ====
// Link between the register side and the serial engine.
// Assumes both ends run on pclk; strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
interface sams_eng_if
   import sams_pkg::*;
   ;
   logic run;
   logic master;
   sams_fmt_t fmt;
   logic fall_en;
   logic rise_en;
   logic lr_in;
   logic sdi_in;
   logic [SAMS_DW-1:0] tx_l;
   logic [SAMS_DW-1:0] tx_r;
   logic frame_start;
   logic [SAMS_DW-1:0] rx_l;
   logic [SAMS_DW-1:0] rx_r;
   logic rx_done;
   logic sdo;
   logic lr_out;

   modport ctl(output run, master, fmt, fall_en, rise_en, lr_in, sdi_in,
      tx_l, tx_r, input frame_start, rx_l, rx_r, rx_done, sdo, lr_out);
   modport eng(input run, master, fmt, fall_en, rise_en, lr_in, sdi_in,
      tx_l, tx_r, output frame_start, rx_l, rx_r, rx_done, sdo, lr_out);
endinterface
`default_nettype wire

// ==== sams_engine.sv ====
// Serial engine: frame position, data placement per format, capture.
// Assumes fall_en and rise_en never coincide and run gates both.
`timescale 1ns/1ps
`default_nettype none
module sams_engine
   import sams_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   sams_eng_if.eng e
);

   logic [SAMS_POS_W-1:0] pos_r;
   logic [SAMS_POS_W-1:0] pos_nxt;
   logic resync_r;
   logic lr_prev_r;
   logic seen_r;
   logic load;
   logic frame_edge;
   logic sdo_r;
   logic lr_r;
   logic fs_r;
   logic rxd_r;
   logic [SAMS_DW-1:0] cur_l_r;
   logic [SAMS_DW-1:0] cur_r_r;
   logic [SAMS_DW-1:0] sh_l_r;
   logic [SAMS_DW-1:0] sh_r_r;
   logic [SAMS_DW-1:0] rx_l_r;
   logic [SAMS_DW-1:0] rx_r_r;
   logic [SAMS_DW-1:0] d_word;
   logic [5:0] d_slot;
   logic [5:0] s_slot;

   // Returns {valid, channel, bit index} for a frame position
   function automatic logic [5:0] slot(input logic [SAMS_POS_W-1:0] p,
                                       input sams_fmt_t f);
      logic [4:0] off;
      logic [4:0] k;
      logic v;
      logic ch;
      off = (f == SAMS_FMT_I2S) ? SAMS_OFF_I2S :
            (f == SAMS_FMT_RJ) ? SAMS_OFF_RJ : SAMS_OFF_LJ;
      if (f == SAMS_FMT_PCM) begin
         v = ~p[SAMS_CH_BIT];
         ch = p[SAMS_PCM_CH_BIT];
         k = {1'b0, p[3:0]};
      end else begin
         ch = p[SAMS_CH_BIT];
         k = p[4:0] - off;
         v = (p[4:0] >= off) && (k < SAMS_DATA_BITS);
      end
      return {v, ch, k[3:0]};
   endfunction

   function automatic logic lr_of(input logic [SAMS_POS_W-1:0] p,
                                  input sams_fmt_t f);
      case (f)
         SAMS_FMT_I2S: return p[SAMS_CH_BIT];
         SAMS_FMT_PCM: return p == SAMS_POS_FIRST;
         default: return ~p[SAMS_CH_BIT];
      endcase
   endfunction

   assign pos_nxt = resync_r ? SAMS_POS_RESYNC : pos_r + 1'b1;
   assign load = e.fall_en && (pos_nxt == SAMS_POS_FIRST);
   assign d_slot = slot(pos_nxt, e.fmt); // [R14]
   assign s_slot = slot(pos_r, e.fmt);
   assign d_word = d_slot[4] ? (load ? e.tx_r : cur_r_r)
                             : (load ? e.tx_l : cur_l_r);
   assign frame_edge = (e.fmt == SAMS_FMT_I2S) ? (lr_prev_r & ~e.lr_in)
                                               : (~lr_prev_r & e.lr_in);

   // Drive side: one step per falling bit clock, every frame carries data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_r <= SAMS_POS_LAST;
         sdo_r <= 1'b0;
         lr_r <= 1'b0;
         fs_r <= 1'b0;
         seen_r <= 1'b0;
         cur_l_r <= SAMS_ZERO16;
         cur_r_r <= SAMS_ZERO16;
      end else begin
         fs_r <= load;
         if (!e.run) begin
            pos_r <= SAMS_POS_LAST;
            sdo_r <= 1'b0;
            lr_r <= 1'b0;
            seen_r <= 1'b0;
         end else if (e.fall_en) begin
            pos_r <= pos_nxt; // [R12]
            sdo_r <= d_slot[5] & d_word[~d_slot[3:0]];
            lr_r <= lr_of(pos_nxt, e.fmt); // [R13]
            if (load) begin
               cur_l_r <= e.tx_l;
               cur_r_r <= e.tx_r;
            end
            // First handover only after a whole frame was sampled
            if (pos_nxt == SAMS_POS_LAST) begin
               seen_r <= 1'b1;
            end
         end
      end
   end

   // Sample side: capture on rising bit clock, hand over at frame wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resync_r <= 1'b0;
         lr_prev_r <= 1'b0;
         rxd_r <= 1'b0;
         sh_l_r <= SAMS_ZERO16;
         sh_r_r <= SAMS_ZERO16;
         rx_l_r <= SAMS_ZERO16;
         rx_r_r <= SAMS_ZERO16;
      end else begin
         rxd_r <= 1'b0;
         if (!e.run) begin
            resync_r <= 1'b0;
         end else if (e.fall_en) begin
            resync_r <= 1'b0;
         end else if (e.rise_en) begin
            lr_prev_r <= e.lr_in;
            resync_r <= ~e.master & frame_edge;
            if (pos_r == SAMS_POS_FIRST && seen_r) begin
               rx_l_r <= sh_l_r;
               rx_r_r <= sh_r_r;
               rxd_r <= 1'b1; // [R12]
            end
            if (s_slot[5] && s_slot[4]) begin
               sh_r_r <= {sh_r_r[SAMS_DW-2:0], e.sdi_in};
            end else if (s_slot[5]) begin
               sh_l_r <= {sh_l_r[SAMS_DW-2:0], e.sdi_in};
            end
         end
      end
   end

   assign e.sdo = sdo_r;
   assign e.lr_out = lr_r;
   assign e.frame_start = fs_r;
   assign e.rx_done = rxd_r;
   assign e.rx_l = rx_l_r;
   assign e.rx_r = rx_r_r;

   property p_pos_step;
      @(posedge pclk) disable iff (!presetn)
      (e.run && e.master && e.fall_en) |=> (pos_r == $past(pos_r) + 1'b1);
   endproperty
   a_pos_step: assert property (p_pos_step) // [R12]
      else $error("Frame position did not advance on bit clock");

   property p_pcm_sync;
      @(posedge pclk) disable iff (!presetn)
      (e.run && e.fmt == SAMS_FMT_PCM && lr_r) |-> (pos_r == SAMS_POS_FIRST);
   endproperty
   a_pcm_sync: assert property (p_pcm_sync) // [R14]
      else $error("PCM frame sync high away from frame start");

   property p_i2s_lr;
      @(posedge pclk) disable iff (!presetn)
      (e.run && e.fmt == SAMS_FMT_I2S && e.fall_en)
         |=> (lr_r == pos_r[SAMS_CH_BIT]);
   endproperty
   a_i2s_lr: assert property (p_i2s_lr) // [R13]
      else $error("I2S channel clock does not follow channel half");

endmodule // sams_engine
`default_nettype wire

// ==== sams_codec.sv ====
// Far-side codec model: echoes the port's serial data back.
// Assumes the port is master and drives both clocks.
`timescale 1ns/1ps
`default_nettype none
module sams_codec (
   input wire logic sck,
   input wire logic sdo,
   output logic sdi
);
   assign sdi = sdo;
endmodule // sams_codec
`default_nettype wire

// ==== tb.sv ====
// Testbench of the audio-mode serial port over APB.
// Assumes a codec echo model at the pins and 100 MHz pclk.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sams_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, irq, sdi, sdo;
   logic pready, pslverr, sck, sck_oe_n, lr, lr_oe_n;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [2:0] irq_priority;
   int n_mismatch = 0;
   int samples_checked = 0;
   time t0;
   sams_top sams_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .irq_priority(irq_priority), .bit_clock_pin_i(1'b0),
      .bit_clock_pin_o(sck), .bit_clock_pin_oe_n(sck_oe_n),
      .channel_clock_i(1'b0), .channel_clock_o(lr),
      .channel_clock_oe_n(lr_oe_n), .serial_data_i(sdi),
      .serial_data_o(sdo));
   sams_codec sams_codec_inst (.sck(sck), .sdo(sdo), .sdi(sdi));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask
   task automatic xf(input logic [7:0] a, input logic w, input logic [15:0] d);
      @(posedge pclk);
      paddr <= a;
      pwrite <= w;
      pwdata <= {16'h0000, d};
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic wait_irq;
      for (int i = 0; i < 2000 && irq !== 1'b1; i++) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
   endtask
   task automatic tally_and_finish;
      $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #200000;
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      presetn = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      xf(SAMS_A_CON1L, 1'b0, 16'h0); chk(q, 32'h0);
      chk({31'h0, sck_oe_n & lr_oe_n}, 32'h1);
      xf(8'h3c, 1'b0, 16'h0); chk({31'h0, pslverr}, 32'h1);
      xf(SAMS_A_PRIO, 1'b1, 16'h0005); chk(irq_priority, 32'h5);
      for (int f = 0; f < 4; f++) begin
         xf(SAMS_A_CON1H, 1'b1, 16'h8000 | f[15:0]);
         xf(SAMS_A_CON1H, 1'b0, 16'h0); chk(q, 32'h8000 | f);
      end
      xf(SAMS_A_BUFL, 1'b1, 16'h0);
      xf(SAMS_A_BUFH, 1'b1, 16'h0);
      // Divider 4 leaves the echo time to pass the pin synchroniser
      xf(SAMS_A_BAUD, 1'b1, 16'h0004);
      xf(SAMS_A_URL, 1'b1, 16'h0f0f);
      xf(SAMS_A_URH, 1'b1, 16'h1234);
      xf(SAMS_A_FLAG, 1'b0, 16'h0);
      xf(SAMS_A_MSKL, 1'b1, 16'h0001);
      xf(SAMS_A_STATL, 1'b1, 16'h0);
      xf(SAMS_A_CON1L, 1'b1, 16'h8020);
      xf(SAMS_A_STATH, 1'b0, 16'h0); chk(q, 32'h0);
      xf(SAMS_A_BUFH, 1'b1, 16'ha5c3);
      xf(SAMS_A_BUFL, 1'b1, 16'h3c5a);
      xf(SAMS_A_STATH, 1'b0, 16'h0); chk(q, 32'h3);
      @(posedge sck);
      t0 = $time;
      @(posedge sck);
      chk(32'(($time - t0) / 10), 32'd10);
      wait_irq();
      xf(SAMS_A_FLAG, 1'b0, 16'h0); chk({31'h0, q[0]}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      xf(SAMS_A_BUFH, 1'b0, 16'h0); chk(q, 32'ha5c3);
      xf(SAMS_A_BUFL, 1'b0, 16'h0); chk(q, 32'h3c5a);
      wait_irq();
      xf(SAMS_A_FLAG, 1'b0, 16'h0); chk({31'h0, q[3]}, 32'h1);
      xf(SAMS_A_BUFH, 1'b0, 16'h0); chk(q, 32'h1234);
      repeat (1600) @(posedge pclk);
      xf(SAMS_A_STATL, 1'b0, 16'h0); chk({31'h0, q[6]}, 32'h1);
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
